// ### pkg/xmc_port_regs.vh
`ifndef XMC_PORT_REGS_VH
`define XMC_PORT_REGS_VH

// Register offsets within the port register space
`define XMC_ADDR_W 16
`define XMC_OFS_CTL_A 16'h0300
`define XMC_OFS_CTL_B 16'h0301

// Field positions, first port control register
`define XMC_A_DUPLEX_BIT 6
`define XMC_A_TX_FC_BIT 5
`define XMC_A_SPEED100_BIT 4
`define XMC_A_RX_FC_BIT 3

// Field positions, second port control register
`define XMC_B_SPEED10_100_BIT 6
`define XMC_B_INGRESS_DLY_BIT 4
`define XMC_B_EGRESS_DLY_BIT 3
`define XMC_B_ROLE_BIT 2
`define XMC_B_IFTYPE_MSB 1
`define XMC_B_IFTYPE_LSB 0

// Reset values of the fixed fields
`define XMC_RST_DUPLEX 1'h1
`define XMC_RST_TX_FC 1'h0
`define XMC_RST_SPEED100 1'h1
`define XMC_RST_RX_FC 1'h0
`define XMC_RST_INGRESS_DLY 1'h0
`define XMC_RST_EGRESS_DLY 1'h1
`define XMC_RST_RESERVED 1'h0

// Interface type encodings
`define XMC_IF_MII 2'h0
`define XMC_IF_RMII 2'h1
`define XMC_IF_RESERVED 2'h2
`define XMC_IF_RGMII 2'h3

// Timing
`define XMC_CLOCK_DELAY_MIN_PS 1500
`define XMC_CLK_PERIOD_NS 25
`define XMC_REFCLK_MHZ 50
`define XMC_STRAP_SYNC_CYCLES 2'h2
`define XMC_LINK_TIMEOUT_CYCLES 8'h40

`endif

// ### hw/xmc_clk_mon.v
`timescale 1ns/1ps
`include "xmc_port_regs.vh"

// Samples the receive clock pin in the local clock domain, finds its edges
// and reports whether the clock is running.
module xmc_clk_mon #(
    parameter TIMEOUT = 64
) (
    // Clock and reset
    input wire i_clock,
    input wire i_rst_n,
    // Pin level
    input wire i_pin,
    // Status
    output wire o_rise,
    output wire o_fall,
    output reg o_present
);

reg sync_0;
reg sync_1;
reg last;
reg [7:0] idle_cnt;
wire edge_seen;

always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
        sync_0 <= 1'b0;
        sync_1 <= 1'b0;
        last <= 1'b0;
    end else begin
        sync_0 <= i_pin;
        sync_1 <= sync_0;
        last <= sync_1;
    end
end

assign o_rise = sync_1 & ~last;
assign o_fall = ~sync_1 & last;
assign edge_seen = o_rise | o_fall;

// Clock is declared absent after TIMEOUT cycles without an edge
always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
        idle_cnt <= 8'h00;
        o_present <= 1'b0;
    end else if (edge_seen) begin
        idle_cnt <= 8'h00;
        o_present <= 1'b1;
    end else if (idle_cnt == TIMEOUT[7:0] - 8'h01) begin
        o_present <= 1'b0;
    end else begin
        idle_cnt <= idle_cnt + 8'h01;
    end
end

endmodule // xmc_clk_mon

// ### hw/xmc_port_ctl.v
`timescale 1ns/1ps
`include "xmc_port_regs.vh"

// Overview of operation
// - First register bit 6 selects full (1) or half (0) duplex; resets to 1.
// - First register bit 5 enables transmit flow control; resets to 0.
// - First register bit 3 enables receive flow control; resets to 0.
// - Without gigabit, first register bit 4 selects 100 (1) or 10 (0) Mb/s.
// - The 10/100 bit is ignored whenever gigabit operation is selected.
// - Second register bit 6 clear selects 1000 Mb/s on RGMII only; set defers to 10/100 bit.
// - Second register bit 4 adds at least 1.5 ns ingress clock delay on RGMII only; resets 0.
// - Second register bit 3 adds at least 1.5 ns egress clock delay on RGMII only; resets 1.
// - In MII, role bit 1 means MAC receiving clocks; 0 means PHY driving clocks.
// - In RMII, role bit 1 receives 50 MHz reference; 0 generates it on pin.
// - Bits 1:0 select MII 00, RMII 01, RGMII 11; 10 is reserved.
// - Gigabit bit, role bit and interface type load from straps at reset.
module xmc_port_ctl #(
    parameter LINK_TIMEOUT = 64,
    parameter REFCLK_HALF_CYCLES = 1
) (
    // Clock and reset
    input wire i_clock,
    input wire i_rst_n,
    // Register access port
    input wire [15:0] i_reg_addr,
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [7:0] i_reg_wdata,
    output reg [7:0] o_reg_rdata,
    output reg o_reg_rvalid,
    output wire o_straps_loaded,
    // Configuration straps
    input wire i_speed_strap_pin,
    input wire i_role_strap_pin,
    input wire [1:0] i_iftype_strap_pin,
    // Receive clock pin
    input wire i_receive_clock_pin,
    output reg o_receive_clock_pin,
    output wire o_receive_clock_pin_oe,
    // Decoded interface configuration
    output reg o_if_mii,
    output reg o_if_rmii,
    output reg o_if_rgmii,
    output reg o_speed_1000,
    output reg o_speed_100,
    output reg o_speed_10,
    output reg o_full_duplex,
    output reg o_tx_flow_control_enable,
    output reg o_rx_flow_control_enable,
    output reg o_ingress_clock_delay_enable,
    output reg o_egress_clock_delay_enable,
    output reg o_mii_mac_role,
    output reg o_rmii_refclk_input,
    output reg o_drive_clocks,
    // Link clock status
    output wire o_link_clock_present,
    output wire o_link_clock_rise
);

// Sequencer states
localparam ST_SYNC = 2'h0;
localparam ST_LOAD = 2'h1;
localparam ST_RUN = 2'h2;

// Strap synchronisers
reg [3:0] strap_sync_0;
reg [3:0] strap_sync_1;
reg [1:0] strap_cnt;
reg [1:0] state;
reg [1:0] next_state;

// Stored fields, first port control register
reg duplex;
reg tx_fc;
reg speed100;
reg rx_fc;

// Stored fields, second port control register
reg speed10_100;
reg ingress_dly;
reg egress_dly;
reg role;
reg [1:0] iftype;

// Reference clock divider
reg [7:0] div_cnt;

// Registered link status
reg link_present;
reg link_rise;

wire sel_a;
wire sel_b;
wire wr_a;
wire wr_b;
wire load_straps;
wire [7:0] ctl_a_value;
wire [7:0] ctl_b_value;
wire clk_present_raw;
wire rise_raw;
wire gig_sel;

assign sel_a = (i_reg_addr == `XMC_OFS_CTL_A);
assign sel_b = (i_reg_addr == `XMC_OFS_CTL_B);
assign wr_a = i_reg_wr & sel_a & (state == ST_RUN);
assign wr_b = i_reg_wr & sel_b & (state == ST_RUN);
assign load_straps = (state == ST_LOAD);
assign o_straps_loaded = (state == ST_RUN);
assign gig_sel = (iftype == `XMC_IF_RGMII) & ~speed10_100;

// Straps are pins, so they pass two flip-flops before use
always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
        strap_sync_0 <= 4'h0;
        strap_sync_1 <= 4'h0;
    end else begin
        strap_sync_0 <= {i_speed_strap_pin, i_role_strap_pin, i_iftype_strap_pin};
        strap_sync_1 <= strap_sync_0;
    end
end

// Sequencer: wait for the synchroniser to fill, load straps once, then run
always @* begin
    next_state = state;
    case (state)
        ST_SYNC: begin
            if (strap_cnt == `XMC_STRAP_SYNC_CYCLES - 2'h1) begin
                next_state = ST_LOAD;
            end
        end
        ST_LOAD: begin
            next_state = ST_RUN;
        end
        ST_RUN: begin
            next_state = ST_RUN;
        end
        default: begin
            next_state = ST_SYNC;
        end
    endcase
end

always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
        state <= ST_SYNC;
        strap_cnt <= 2'h0;
    end else begin
        state <= next_state;
        if (state == ST_SYNC) begin
            strap_cnt <= strap_cnt + 2'h1;
        end
    end
end

// First port control register
always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
        duplex <= `XMC_RST_DUPLEX;
        tx_fc <= `XMC_RST_TX_FC;
        speed100 <= `XMC_RST_SPEED100;
        rx_fc <= `XMC_RST_RX_FC;
    end else if (wr_a) begin
        duplex <= i_reg_wdata[`XMC_A_DUPLEX_BIT];
        tx_fc <= i_reg_wdata[`XMC_A_TX_FC_BIT];
        speed100 <= i_reg_wdata[`XMC_A_SPEED100_BIT];
        rx_fc <= i_reg_wdata[`XMC_A_RX_FC_BIT];
    end
end

// Second port control register; strap fields load before any write is taken
always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
        speed10_100 <= 1'b0;
        ingress_dly <= `XMC_RST_INGRESS_DLY;
        egress_dly <= `XMC_RST_EGRESS_DLY;
        role <= 1'b0;
        iftype <= `XMC_IF_MII;
    end else if (load_straps) begin
        speed10_100 <= strap_sync_1[3];
        role <= strap_sync_1[2];
        iftype <= strap_sync_1[1:0];
    end else if (wr_b) begin
        speed10_100 <= i_reg_wdata[`XMC_B_SPEED10_100_BIT];
        ingress_dly <= i_reg_wdata[`XMC_B_INGRESS_DLY_BIT];
        egress_dly <= i_reg_wdata[`XMC_B_EGRESS_DLY_BIT];
        role <= i_reg_wdata[`XMC_B_ROLE_BIT];
        iftype <= i_reg_wdata[`XMC_B_IFTYPE_MSB:`XMC_B_IFTYPE_LSB];
    end
end

// Reserved bits are not stored and read back their reset value
assign ctl_a_value = {`XMC_RST_RESERVED, duplex, tx_fc, speed100, rx_fc,
                      `XMC_RST_RESERVED, `XMC_RST_RESERVED, `XMC_RST_RESERVED};
assign ctl_b_value = {`XMC_RST_RESERVED, speed10_100, `XMC_RST_RESERVED, ingress_dly,
                      egress_dly, role, iftype};

// Read data one cycle after the strobe; unmapped offsets read zero
always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
        o_reg_rdata <= 8'h00;
        o_reg_rvalid <= 1'b0;
    end else begin
        o_reg_rvalid <= i_reg_rd;
        if (i_reg_rd & sel_a) begin
            o_reg_rdata <= ctl_a_value;
        end else if (i_reg_rd & sel_b) begin
            o_reg_rdata <= ctl_b_value;
        end else if (i_reg_rd) begin
            o_reg_rdata <= 8'h00;
        end
    end
end

// Decoded configuration, registered
always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
        o_if_mii <= 1'b0;
        o_if_rmii <= 1'b0;
        o_if_rgmii <= 1'b0;
        o_speed_1000 <= 1'b0;
        o_speed_100 <= 1'b0;
        o_speed_10 <= 1'b0;
        o_full_duplex <= 1'b0;
        o_tx_flow_control_enable <= 1'b0;
        o_rx_flow_control_enable <= 1'b0;
        o_ingress_clock_delay_enable <= 1'b0;
        o_egress_clock_delay_enable <= 1'b0;
        o_mii_mac_role <= 1'b0;
        o_rmii_refclk_input <= 1'b0;
        o_drive_clocks <= 1'b0;
    end else if (state != ST_RUN) begin
        o_if_mii <= 1'b0;
        o_if_rmii <= 1'b0;
        o_if_rgmii <= 1'b0;
        o_drive_clocks <= 1'b0;
    end else begin
        o_if_mii <= (iftype == `XMC_IF_MII);
        o_if_rmii <= (iftype == `XMC_IF_RMII);
        o_if_rgmii <= (iftype == `XMC_IF_RGMII);
        // Gigabit only exists on RGMII; while gigabit is selected the 10/100 bit is ignored
        o_speed_1000 <= gig_sel;
        o_speed_100 <= ~gig_sel & speed100;
        o_speed_10 <= ~gig_sel & ~speed100;
        o_full_duplex <= duplex;
        o_tx_flow_control_enable <= tx_fc;
        o_rx_flow_control_enable <= rx_fc;
        o_ingress_clock_delay_enable <= ingress_dly & (iftype == `XMC_IF_RGMII);
        o_egress_clock_delay_enable <= egress_dly & (iftype == `XMC_IF_RGMII);
        o_mii_mac_role <= (iftype == `XMC_IF_MII) & role;
        o_rmii_refclk_input <= (iftype == `XMC_IF_RMII) & role;
        // PHY-role MII and generated-reference RMII both source the clock
        o_drive_clocks <= ((iftype == `XMC_IF_MII) | (iftype == `XMC_IF_RMII)) & ~role;
    end
end

// Clock driven out on the receive clock pin; the nominal 50 MHz reference
// comes from a faster clock in silicon, here a divider of i_clock stands in
always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
        div_cnt <= 8'h00;
        o_receive_clock_pin <= 1'b0;
    end else if (!o_drive_clocks) begin
        div_cnt <= 8'h00;
        o_receive_clock_pin <= 1'b0;
    end else if (div_cnt == REFCLK_HALF_CYCLES[7:0] - 8'h01) begin
        div_cnt <= 8'h00;
        o_receive_clock_pin <= ~o_receive_clock_pin;
    end else begin
        div_cnt <= div_cnt + 8'h01;
    end
end

assign o_receive_clock_pin_oe = o_drive_clocks;

// Partner clock presence is reported only when this end does not drive it; rise pulses pass ungated
xmc_clk_mon #(
    .TIMEOUT(LINK_TIMEOUT)
) u_clk_mon (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_pin(i_receive_clock_pin),
    .o_rise(rise_raw),
    .o_fall(),
    .o_present(clk_present_raw)
);

// Status flops keep the link outputs free of decode glitches
always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
        link_present <= 1'b0;
        link_rise <= 1'b0;
    end else begin
        link_present <= clk_present_raw & ~o_drive_clocks;
        link_rise <= rise_raw;
    end
end

assign o_link_clock_present = link_present;
assign o_link_clock_rise = link_rise;

endmodule // xmc_port_ctl

// ### bench/xmc_port_ctl_chk.sv
`timescale 1ns/1ps
module xmc_port_ctl_chk (
    // Clock, reset and register port
    input wire i_clock,
    input wire i_rst_n,
    input wire [15:0] i_reg_addr,
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [7:0] i_reg_wdata,
    input wire [7:0] o_reg_rdata,
    input wire o_straps_loaded,
    // Decoded configuration
    input wire o_receive_clock_pin_oe,
    input wire o_if_mii,
    input wire o_if_rmii,
    input wire o_if_rgmii,
    input wire o_speed_1000,
    input wire o_speed_100,
    input wire o_speed_10,
    input wire o_full_duplex,
    input wire o_tx_flow_control_enable,
    input wire o_mii_mac_role,
    input wire o_rmii_refclk_input
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    wire wr_a = i_reg_wr && o_straps_loaded && i_reg_addr == 16'h0300;
    wire any_if = o_if_mii | o_if_rmii | o_if_rgmii;

    chk_duplex_write: assert property (wr_a |-> ##2 o_full_duplex == $past(i_reg_wdata[6], 2))
        else $error("duplex does not follow write");
    chk_txfc_write: assert property (wr_a |-> ##2 o_tx_flow_control_enable == $past(i_reg_wdata[5], 2))
        else $error("tx flow control does not follow write");
    chk_speed_onehot: assert property (any_if |-> $onehot({o_speed_1000, o_speed_100, o_speed_10}))
        else $error("speed not one-hot");
    chk_gig_holds: assert property (o_speed_1000 && wr_a |-> ##2 o_speed_1000)
        else $error("gigabit lost on 10/100 write");
    chk_gig_rgmii: assert property (o_speed_1000 |-> o_if_rgmii)
        else $error("gigabit outside rgmii");
    chk_mac_role: assert property (o_mii_mac_role |-> o_if_mii && !o_receive_clock_pin_oe)
        else $error("mac role drives clock");
    chk_refclk_in: assert property (o_rmii_refclk_input |-> o_if_rmii && !o_receive_clock_pin_oe)
        else $error("reference input drives pin");
    chk_type_onehot: assert property ($onehot0({o_if_mii, o_if_rmii, o_if_rgmii}))
        else $error("several interface types");
    chk_rsvd_read: assert property (i_reg_rd && i_reg_addr == 16'h0300 |=> o_reg_rdata[7] == 1'b0 && o_reg_rdata[2:0] == 3'h0)
        else $error("reserved bits read nonzero");
endmodule // xmc_port_ctl_chk

bind xmc_port_ctl xmc_port_ctl_chk u_chk (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd),
    .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata),
    .o_straps_loaded(o_straps_loaded),
    .o_receive_clock_pin_oe(o_receive_clock_pin_oe),
    .o_if_mii(o_if_mii),
    .o_if_rmii(o_if_rmii),
    .o_if_rgmii(o_if_rgmii),
    .o_speed_1000(o_speed_1000),
    .o_speed_100(o_speed_100),
    .o_speed_10(o_speed_10),
    .o_full_duplex(o_full_duplex),
    .o_tx_flow_control_enable(o_tx_flow_control_enable),
    .o_mii_mac_role(o_mii_mac_role),
    .o_rmii_refclk_input(o_rmii_refclk_input)
);

// ### bench/xmc_link_partner.sv
`timescale 1ns/1ps
module xmc_link_partner (
    input wire i_oe,
    input wire i_dev_clk,
    output logic o_pin
);
    logic ref_clk = 1'b0;
    // Free-running clock, given up whenever the device drives the pin
    always #100 ref_clk = ~ref_clk;
    always @* o_pin = i_oe ? i_dev_clk : ref_clk;
endmodule // xmc_link_partner

// ### bench/xmc_port_ctl_test.sv
`timescale 1ns/1ps
module xmc_port_ctl_test;
    logic i_clock, i_rst_n, i_reg_wr, i_reg_rd, i_speed_strap_pin, i_role_strap_pin, i_receive_clock_pin;
    logic [15:0] i_reg_addr;
    logic [7:0] i_reg_wdata, o_reg_rdata;
    logic [1:0] i_iftype_strap_pin, t;
    logic o_reg_rvalid, o_straps_loaded, o_receive_clock_pin, o_receive_clock_pin_oe, o_if_mii, o_if_rmii;
    logic o_if_rgmii, o_speed_1000, o_speed_100, o_speed_10, o_full_duplex, o_tx_flow_control_enable;
    logic o_rx_flow_control_enable, o_ingress_clock_delay_enable, o_egress_clock_delay_enable;
    logic o_mii_mac_role, o_rmii_refclk_input, o_drive_clocks, o_link_clock_present, o_link_clock_rise;
    logic r, prev, seen;
    logic [5:0] e;
    int fails = 0;
    int samples_checked = 0;

    xmc_port_ctl #(.LINK_TIMEOUT(16)) DUT (.*);
    xmc_link_partner u_partner (.i_oe(o_receive_clock_pin_oe), .i_dev_clk(o_receive_clock_pin),
        .o_pin(i_receive_clock_pin));

    initial begin
        i_clock = 1'b0;
        forever #12.5 i_clock = ~i_clock;
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        tick(1);
        i_reg_wr = 1'b1;
        i_reg_addr = a;
        i_reg_wdata = d;
        tick(1);
        i_reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string name);
        tick(1);
        i_reg_rd = 1'b1;
        i_reg_addr = a;
        tick(1);
        i_reg_rd = 1'b0;
        check(name, o_reg_rvalid ? o_reg_rdata : 8'hxx, exp);
    endtask

    // Reset with given straps; a write issued before the load must be dropped
    task automatic restart(input logic sp, input logic ro, input logic [1:0] ty);
        i_rst_n = 1'b0;
        i_speed_strap_pin = sp;
        i_role_strap_pin = ro;
        i_iftype_strap_pin = ty;
        tick(5);
        i_rst_n = 1'b1;
        wr(16'h0300, 8'h00);
        for (int n = 0; n < 20 && o_straps_loaded !== 1'b1; n++) tick(1);
        if (o_straps_loaded !== 1'b1) begin
            fails++;
            print_verdict();
        end
    endtask

    initial begin
        {i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} = '0;
        restart(1'b1, 1'b0, 2'h1);
        rd(16'h0300, 8'h50, "ctl a reset");
        rd(16'h0301, 8'h49, "ctl b reset");
        check("speed 100", o_speed_100, 8'h01);
        wr(16'h0300, 8'h00);
        tick(2);
        check("half 10", {o_full_duplex, o_speed_10}, 8'h01);
        wr(16'h0300, 8'hff);
        rd(16'h0300, 8'h78, "ctl a reserved");
        check("a fields", {o_full_duplex, o_tx_flow_control_enable, o_rx_flow_control_enable, o_speed_100}, 8'h0f);
        wr(16'h0301, 8'hff);
        rd(16'h0301, 8'h5f, "ctl b reserved");
        check("rgmii 100", {o_if_rgmii, o_speed_100, o_ingress_clock_delay_enable, o_egress_clock_delay_enable}, 8'h0f);
        wr(16'h0301, 8'h03);
        tick(2);
        check("gig", {o_speed_1000, o_ingress_clock_delay_enable, o_egress_clock_delay_enable}, 8'h04);
        wr(16'h0300, 8'h40);
        tick(2);
        check("gig kept", o_speed_1000, 8'h01);
        rd(16'h0302, 8'h00, "unmapped");
        for (int k = 0; k < 8; k++) begin
            t = k[1:0];
            r = k[2];
            wr(16'h0301, {5'h09, r, t});
            tick(24);
            e = {t == 2'h0, t == 2'h1, t == 2'h3, t == 2'h0 && r, t == 2'h1 && r, !t[1] && !r};
            check("decode", {o_if_mii, o_if_rmii, o_if_rgmii, o_mii_mac_role, o_rmii_refclk_input, o_drive_clocks}, e);
            check("oe", o_receive_clock_pin_oe, e[0]);
            check("present", o_link_clock_present, !e[0]);
            prev = o_receive_clock_pin;
            tick(1);
            if (e[0]) check("refclk", o_receive_clock_pin ^ prev, 8'h01);
            else check("refclk idle", o_receive_clock_pin, 8'h00);
            seen = 1'b0;
            for (int n = 0; n < 16 && !e[0] && seen !== 1'b1; n++) begin
                tick(1);
                seen = o_link_clock_rise;
            end
            if (!e[0]) check("rise", seen, 8'h01);
        end
        restart(1'b0, 1'b1, 2'h0);
        rd(16'h0300, 8'h50, "early write");
        rd(16'h0301, 8'h0c, "ctl b straps");
        check("mac role", o_mii_mac_role, 8'h01);
        print_verdict();
    end
endmodule // xmc_port_ctl_test
